/* irt_pkg.sv */
// shared constants and types for the inductive result and threshold logic
`default_nettype none
package irt_pkg;
  // register addresses
  localparam logic [6:0] IRT_A_ID = 7'h00;
  localparam logic [6:0] IRT_A_UPPER = 7'h01;
  localparam logic [6:0] IRT_A_LOWER = 7'h02;
  localparam logic [6:0] IRT_A_SFREQ = 7'h03;
  localparam logic [6:0] IRT_A_SCFG = 7'h04;
  localparam logic [6:0] IRT_A_CLKCFG = 7'h05;
  localparam logic [6:0] IRT_A_THI_L = 7'h06;
  localparam logic [6:0] IRT_A_THI_H = 7'h07;
  localparam logic [6:0] IRT_A_TLO_L = 7'h08;
  localparam logic [6:0] IRT_A_TLO_H = 7'h09;
  localparam logic [6:0] IRT_A_INTCFG = 7'h0a;
  localparam logic [6:0] IRT_A_PWRCFG = 7'h0b;
  localparam logic [6:0] IRT_A_STATUS = 7'h20;
  localparam logic [6:0] IRT_A_PROX_L = 7'h21;
  localparam logic [6:0] IRT_A_PROX_H = 7'h22;
  localparam logic [6:0] IRT_A_FREQ_L = 7'h23;
  localparam logic [6:0] IRT_A_FREQ_M = 7'h24;
  localparam logic [6:0] IRT_A_FREQ_H = 7'h25;
  // values after reset
  localparam logic [7:0] IRT_R_UPPER = 8'h0e;
  localparam logic [7:0] IRT_R_LOWER = 8'h14;
  localparam logic [7:0] IRT_R_SFREQ = 8'h45;
  localparam logic [7:0] IRT_R_SCFG = 8'h1b;
  localparam logic [7:0] IRT_R_CLKCFG = 8'h01;
  localparam logic [15:0] IRT_R_THI = 16'hffff;
  localparam logic [15:0] IRT_R_TLO = 16'h0000;
  localparam logic [2:0] IRT_R_INTCFG = 3'h0;
  // field positions
  localparam int IRT_F_CLK_SEL = 1;
  localparam int IRT_F_CLK_PD = 0;
  localparam int IRT_F_PWR = 0;
  // sensor periods per window at the shortest response time (192 / 3)
  localparam logic [15:0] IRT_WIN_BASE = 16'h0040;
  localparam logic [2:0] IRT_RT_MAX = 3'h5;
  localparam logic [15:0] IRT_FULL_SCALE = 16'hffff;
  typedef enum logic [2:0] {
    IRT_INT_READY = 3'b000,
    IRT_INT_WAKE = 3'b001,
    IRT_INT_CMP = 3'b010
  } irt_int_mode_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } irt_reg_req_t;
  typedef struct packed {
    logic osc_edge;
    logic osc_dead;
    logic [15:0] conductance;
  } irt_sensor_t;
endpackage
`default_nettype wire

/* irt_result_threshold.sv */
// proximity code, frequency counter, register file and interrupt pin logic
`default_nettype none
module irt_result_threshold
  import irt_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire irt_reg_req_t reg_req_in,
  input wire irt_sensor_t sensor_in,
  input wire logic ext_clock_tick_in,
  input wire logic crystal_tick_in,
  output logic [7:0] reg_rdata_out,
  output logic host_interrupt_pin_n_out,
  output logic crystal_drive_output_en_out
);
  logic [7:0] upper_q, lower_q, sfreq_q, scfg_q, clkcfg_q;
  logic [15:0] thr_hi_q, thr_lo_q, prox_q, win_q;
  logic [2:0] intcfg_q;
  logic pwr_q, new_q, ready_q, pulse_q, cmp_q, wake_q;
  logic [23:0] tb_cnt_q, freq_q;
  logic [15:0] g_lo, g_hi, prox_d, win_len;
  logic [30:0] num;
  logic tb_tick, win_end, rd21, cfg_locked, cmp_d, pin_d;
  irt_int_mode_t mode;

  // bound register code to conductance units on the sensor input scale
  function automatic logic [15:0] bound_g(input logic [7:0] code);
    return {code, 8'h00};
  endfunction

  assign mode = irt_int_mode_t'(intcfg_q);
  assign rd21 = reg_req_in.rd && reg_req_in.addr == IRT_A_PROX_L;
  assign cfg_locked = pwr_q;

  // register writes; bounds and clocking frozen while converting
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      upper_q <= IRT_R_UPPER;
      lower_q <= IRT_R_LOWER;
      sfreq_q <= IRT_R_SFREQ;
      scfg_q <= IRT_R_SCFG;
      clkcfg_q <= IRT_R_CLKCFG;
      thr_hi_q <= IRT_R_THI;
      thr_lo_q <= IRT_R_TLO;
      intcfg_q <= IRT_R_INTCFG;
      pwr_q <= 1'b0;
    end else if (ce_in && reg_req_in.wr) begin
      case (reg_req_in.addr)
        IRT_A_UPPER: if (!cfg_locked) upper_q <= reg_req_in.wdata;
        IRT_A_LOWER: if (!cfg_locked) lower_q <= reg_req_in.wdata;
        IRT_A_SFREQ: if (!cfg_locked) sfreq_q <= reg_req_in.wdata;
        IRT_A_SCFG: if (!cfg_locked) scfg_q <= reg_req_in.wdata;
        IRT_A_CLKCFG: if (!cfg_locked) clkcfg_q <= reg_req_in.wdata;
        IRT_A_THI_L: thr_hi_q[7:0] <= reg_req_in.wdata;
        IRT_A_THI_H: thr_hi_q[15:8] <= reg_req_in.wdata;
        IRT_A_TLO_L: thr_lo_q[7:0] <= reg_req_in.wdata;
        IRT_A_TLO_H: thr_lo_q[15:8] <= reg_req_in.wdata;
        IRT_A_INTCFG: intcfg_q <= reg_req_in.wdata[2:0];
        IRT_A_PWRCFG: pwr_q <= reg_req_in.wdata[IRT_F_PWR];
        default: ;
      endcase
    end
  end

  // timebase selection; a powered-down oscillator gives no ticks
  assign tb_tick = !clkcfg_q[IRT_F_CLK_PD] &&
                   (clkcfg_q[IRT_F_CLK_SEL] ? crystal_tick_in : ext_clock_tick_in);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) crystal_drive_output_en_out <= 1'b0;
    else if (ce_in) crystal_drive_output_en_out <=
        clkcfg_q[IRT_F_CLK_SEL] && !clkcfg_q[IRT_F_CLK_PD];
  end

  // window of tres/3 sensor periods, tres doubling per response code up to code 5
  always_comb begin
    if (scfg_q[2:0] > IRT_RT_MAX) win_len = IRT_WIN_BASE << IRT_RT_MAX;
    else win_len = IRT_WIN_BASE << scfg_q[2:0];
  end
  assign win_end = pwr_q && sensor_in.osc_edge && (win_q == win_len - 16'h0001);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      win_q <= 16'h0000;
      tb_cnt_q <= 24'h000000;
      freq_q <= 24'h000000;
    end else if (ce_in) begin
      if (!pwr_q) begin
        win_q <= 16'h0000;
        tb_cnt_q <= 24'h000000;
      end else if (win_end) begin
        win_q <= 16'h0000;
        tb_cnt_q <= 24'h000000;
        freq_q <= tb_cnt_q + {23'h000000, tb_tick};
      end else begin
        if (sensor_in.osc_edge) win_q <= win_q + 16'h0001;
        if (tb_tick) tb_cnt_q <= tb_cnt_q + 24'h000001;
      end
    end
  end

  // proximity code: Y*2^15 = (g - 1/Rmax) / (1/Rmin - 1/Rmax)
  assign g_lo = bound_g(upper_q);
  assign g_hi = bound_g(lower_q);
  assign num = {sensor_in.conductance - g_lo, 15'h0000};
  always_comb begin
    if (g_hi <= g_lo || sensor_in.conductance >= g_hi) prox_d = IRT_FULL_SCALE;
    else if (sensor_in.conductance <= g_lo) prox_d = 16'h0000;
    else prox_d = 16'(num / {15'h0000, g_hi - g_lo});
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prox_q <= 16'h0000;
      new_q <= 1'b0;
    end else if (ce_in) begin
      new_q <= win_end;
      if (win_end) prox_q <= prox_d;
    end
  end

  // comparator with hysteresis, evaluated on each new result
  always_comb begin
    cmp_d = cmp_q;
    if (prox_q > thr_hi_q) cmp_d = 1'b1;
    else if (prox_q < thr_lo_q) cmp_d = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmp_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (ce_in) begin
      if (new_q) cmp_q <= cmp_d;
      if (mode != IRT_INT_WAKE) wake_q <= 1'b0;
      else if (new_q && prox_q > thr_hi_q) wake_q <= 1'b1;
    end
  end

  // data ready: a result racing a 0x21 read shows as a one-cycle pulse
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ready_q <= 1'b0;
      pulse_q <= 1'b0;
    end else if (ce_in) begin
      pulse_q <= new_q && rd21;
      if (new_q) ready_q <= 1'b1;
      else if (rd21 || pulse_q) ready_q <= 1'b0;
    end
  end

  always_comb begin
    case (mode)
      IRT_INT_CMP: pin_d = cmp_q;
      IRT_INT_WAKE: pin_d = wake_q;
      default: pin_d = ready_q;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) host_interrupt_pin_n_out <= 1'b1;
    else if (ce_in) host_interrupt_pin_n_out <= !pin_d;
  end

  // register read port, answered one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) reg_rdata_out <= 8'h00;
    else if (ce_in && reg_req_in.rd) begin
      case (reg_req_in.addr)
        IRT_A_ID: reg_rdata_out <= DEVICE_ID;
        IRT_A_UPPER: reg_rdata_out <= upper_q;
        IRT_A_LOWER: reg_rdata_out <= lower_q;
        IRT_A_SFREQ: reg_rdata_out <= sfreq_q;
        IRT_A_SCFG: reg_rdata_out <= scfg_q;
        IRT_A_CLKCFG: reg_rdata_out <= clkcfg_q;
        IRT_A_THI_L: reg_rdata_out <= thr_hi_q[7:0];
        IRT_A_THI_H: reg_rdata_out <= thr_hi_q[15:8];
        IRT_A_TLO_L: reg_rdata_out <= thr_lo_q[7:0];
        IRT_A_TLO_H: reg_rdata_out <= thr_lo_q[15:8];
        IRT_A_INTCFG: reg_rdata_out <= {5'h00, intcfg_q};
        IRT_A_PWRCFG: reg_rdata_out <= {7'h00, pwr_q};
        IRT_A_STATUS: reg_rdata_out <= {sensor_in.osc_dead, !ready_q, wake_q, cmp_q, 4'h0};
        IRT_A_PROX_L: reg_rdata_out <= prox_q[7:0];
        IRT_A_PROX_H: reg_rdata_out <= prox_q[15:8];
        IRT_A_FREQ_L: reg_rdata_out <= freq_q[7:0];
        IRT_A_FREQ_M: reg_rdata_out <= freq_q[15:8];
        IRT_A_FREQ_H: reg_rdata_out <= freq_q[23:16];
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_prox_sat;
    ce_in && win_end && sensor_in.conductance >= g_hi |=> prox_q == IRT_FULL_SCALE;
  endproperty
  a_prox_sat: assert property (p_prox_sat) else $error("proximity not saturated");

  property p_prox_low_read;
    ce_in && reg_req_in.rd && reg_req_in.addr == IRT_A_PROX_L
      |=> reg_rdata_out == $past(prox_q[7:0]);
  endproperty
  a_prox_low_read: assert property (p_prox_low_read) else $error("bad 0x21 data");

  property p_freq_high_read;
    ce_in && reg_req_in.rd && reg_req_in.addr == IRT_A_FREQ_H
      |=> reg_rdata_out == $past(freq_q[23:16]);
  endproperty
  a_freq_high_read: assert property (p_freq_high_read) else $error("bad 0x25 data");

  property p_cmp_assert;
    ce_in && new_q && mode == IRT_INT_CMP && prox_q > thr_hi_q ##1 ce_in && mode == IRT_INT_CMP
      |=> !host_interrupt_pin_n_out;
  endproperty
  a_cmp_assert: assert property (p_cmp_assert) else $error("pin not asserted above high");

  property p_cmp_clear;
    ce_in && new_q && prox_q < thr_lo_q && prox_q <= thr_hi_q |=> !cmp_q;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("comparator not cleared");

  property p_cmp_hold;
    ce_in && new_q && prox_q >= thr_lo_q && prox_q <= thr_hi_q |=> $stable(cmp_q);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("comparator moved in band");

  property p_wake_hold;
    ce_in && wake_q && mode == IRT_INT_WAKE |=> wake_q;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake dropped early");

  property p_ready_clear;
    ce_in && ready_q && rd21 && !new_q |=> !ready_q;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

  property p_ready_pulse;
    ce_in && new_q && rd21 ##1 ce_in && !new_q |=> !ready_q;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready not pulsed");

  property p_cfg_lock;
    ce_in && pwr_q && reg_req_in.wr && reg_req_in.addr == IRT_A_SCFG |=> $stable(scfg_q);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config written while active");

  property p_wake_clear;
    ce_in && mode != IRT_INT_WAKE |=> !wake_q;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared by mode");

  property p_pin_ready;
    ce_in && mode == IRT_INT_READY |=> host_interrupt_pin_n_out == !$past(ready_q);
  endproperty
  a_pin_ready: assert property (p_pin_ready) else $error("pin not showing ready");

  property p_freq_hold;
    !(ce_in && win_end) |=> $stable(freq_q);
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("count moved between windows");

  property p_prox_hold;
    !(ce_in && win_end) |=> $stable(prox_q);
  endproperty
  a_prox_hold: assert property (p_prox_hold) else $error("code moved between windows");

  property p_prox_zero;
    ce_in && win_end && g_lo < g_hi && sensor_in.conductance <= g_lo |=> prox_q == 16'h0000;
  endproperty
  a_prox_zero: assert property (p_prox_zero) else $error("code not zero at upper bound");

  property p_xtal_drive;
    ce_in |=> crystal_drive_output_en_out ==
      ($past(clkcfg_q[IRT_F_CLK_SEL]) && !$past(clkcfg_q[IRT_F_CLK_PD]));
  endproperty
  a_xtal_drive: assert property (p_xtal_drive) else $error("crystal drive wrong");

  property p_freeze;
    !ce_in |=> $stable(host_interrupt_pin_n_out) && $stable(reg_rdata_out) && $stable(win_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  c_result: cover property (ce_in && win_end);
  c_cmp_trip: cover property (new_q && mode == IRT_INT_CMP && prox_q > thr_hi_q);
  c_race: cover property (new_q && rd21);
  c_wake: cover property (wake_q && mode == IRT_INT_WAKE);
  c_freeze: cover property (!ce_in ##1 ce_in);
endmodule
`default_nettype wire

/* irt_resonator_model.sv */
// resonator and timebase model driving the sensor side of the block
`default_nettype none
module irt_resonator_model
  import irt_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] period_in,
  input wire logic [15:0] conductance_in,
  output irt_sensor_t sensor_out,
  output logic ext_tick_out,
  output logic crystal_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  logic tick_q = 1'b0;
  always @(posedge clk_in) begin
    cnt_q <= #1 (cnt_q + 8'h01 >= period_in) ? 8'h00 : cnt_q + 8'h01;
    tick_q <= #1 ~tick_q;
  end
  // one edge per oscillation period; higher conductance means lower impedance
  assign sensor_out = '{osc_edge: (cnt_q == 8'h00), osc_dead: 1'b0,
                        conductance: conductance_in};
  // timebase runs at half the system clock on both sources
  assign ext_tick_out = tick_q;
  assign crystal_tick_out = tick_q;
endmodule
`default_nettype wire

/* tb_irt_result_threshold.sv */
// self-checking bench for the result and threshold logic
`default_nettype none
module tb_irt_result_threshold
  import irt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  irt_reg_req_t req = '0;
  irt_sensor_t sens;
  logic ext_tick, xtal_tick, pin_n, xtal_en;
  logic [7:0] rdata;
  logic [7:0] period = 8'h08;
  logic [15:0] cond = 16'h2000;
  logic ce = 1'b1;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  irt_result_threshold dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .reg_req_in(req), .sensor_in(sens), .ext_clock_tick_in(ext_tick),
    .crystal_tick_in(xtal_tick), .reg_rdata_out(rdata),
    .host_interrupt_pin_n_out(pin_n), .crystal_drive_output_en_out(xtal_en));
  irt_resonator_model model (.clk_in(clk_in), .period_in(period), .conductance_in(cond),
    .sensor_out(sens), .ext_tick_out(ext_tick), .crystal_tick_out(xtal_tick));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req = '{1'b0, 1'b1, a, d};
    cyc(1);
    req = '0;
    cyc(1);
  endtask
  task automatic rd_raw(input logic [6:0] a);
    req = '{1'b1, 1'b0, a, 8'h00};
    cyc(1);
    req = '0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    rd_raw(a);
    check(rdata, exp);
  endtask
  task automatic pin_is(input logic lvl);
    check({7'h00, pin_n}, {7'h00, lvl});
  endtask
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (pin_n !== lvl && n < 2000) begin
      cyc(1);
      n++;
    end
    pin_is(lvl);
  endtask
  // two windows are drained so the checked one saw only the current settings
  task automatic result(input logic [15:0] prox, input logic [23:0] cnt);
    repeat (2) begin
      wait_pin(1'b0);
      rd_raw(IRT_A_PROX_L);
    end
    wait_pin(1'b0);
    rd(IRT_A_PROX_L, prox[7:0]);
    rd(IRT_A_PROX_H, prox[15:8]);
    rd(IRT_A_FREQ_L, cnt[7:0]);
    rd(IRT_A_FREQ_M, cnt[15:8]);
    rd(IRT_A_FREQ_H, cnt[23:16]);
    pin_is(1'b1);
  endtask
  initial begin
    cyc(4);
    rst_n_in = 1'b1;
    pin_is(1'b1);
    check({7'h00, xtal_en}, 8'h00);
    rd(IRT_A_SCFG, 8'h1b);
    rd(IRT_A_CLKCFG, 8'h01);
    rd(IRT_A_THI_H, 8'hff);
    rd(IRT_A_TLO_L, 8'h00);
    rd(IRT_A_STATUS, 8'h40);
    rd(7'h30, 8'h00);
    wr(IRT_A_CLKCFG, 8'h02);
    check({7'h00, xtal_en}, 8'h01);
    wr(IRT_A_CLKCFG, 8'h00);
    check({7'h00, xtal_en}, 8'h00);
    wr(IRT_A_UPPER, 8'h10);
    wr(IRT_A_LOWER, 8'h30);
    wr(IRT_A_SCFG, 8'h18);
    wr(IRT_A_PWRCFG, 8'h01);
    wr(IRT_A_SCFG, 8'h1b);
    rd(IRT_A_SCFG, 8'h18);
    // 64 edges of 8 cycles, one tick every 2 cycles
    result(16'h4000, 24'h000100);
    // a 0x21 read timed onto the next result: 512-cycle windows, pin seen 2 after
    rd_raw(IRT_A_PROX_L);
    wait_pin(1'b0);
    cyc(510);
    rd_raw(IRT_A_PROX_L);
    pin_is(1'b0);
    cyc(1);
    pin_is(1'b1);
    cond = 16'h3800;
    result(16'hffff, 24'h000100);
    period = 8'h10;
    result(16'hffff, 24'h000200);
    period = 8'h08;
    wr(IRT_A_PWRCFG, 8'h00);
    wr(IRT_A_SCFG, 8'h19);
    wr(IRT_A_PWRCFG, 8'h01);
    result(16'hffff, 24'h000200);
    wr(IRT_A_THI_L, 8'h00);
    wr(IRT_A_THI_H, 8'h80);
    wr(IRT_A_TLO_H, 8'h20);
    wr(IRT_A_INTCFG, 8'h02);
    cyc(2100);
    pin_is(1'b0);
    rd(IRT_A_STATUS, 8'h10);
    cond = 16'h2800;
    cyc(2100);
    pin_is(1'b0);
    cond = 16'h1400;
    cyc(2100);
    pin_is(1'b1);
    wr(IRT_A_INTCFG, 8'h01);
    cond = 16'h3800;
    cyc(2100);
    pin_is(1'b0);
    rd(IRT_A_STATUS, 8'h30);
    cond = 16'h1400;
    cyc(2100);
    pin_is(1'b0);
    wr(IRT_A_INTCFG, 8'h02);
    cyc(4);
    pin_is(1'b1);
    // a write while the clock enable is low must not land
    ce = 1'b0;
    wr(IRT_A_THI_H, 8'h11);
    ce = 1'b1;
    rd(IRT_A_THI_H, 8'h80);
    give_verdict();
  end
endmodule
`default_nettype wire
